// [logic/feeder_prot.sv]
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module feeder_prot import feeder_prot_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire meas_t             meas,
  input  wire logic              breaker_open_status,
  input  wire logic              inrush_block,
  input  wire logic              latch_reset_in,
  input  wire logic              thermal_block_in,
  input  wire logic              thermal_reset_in,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  output logic                   prot_trip,
  output logic                   prot_trip_pulse,
  output logic                   alarm,
  output logic                   thermal_trip,
  output logic                   thermal_start
);
  function automatic logic is_trip(input logic [2:0] m);
    return m == MODE_TRIP || m == MODE_TRIP_INR ||
           m == MODE_TRIP_LTCH || m == MODE_TRIP_BRK;
  endfunction

  function automatic logic is_alarm(input logic [2:0] m);
    return m == MODE_ALARM || m == MODE_ALARM_BRK;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction

  // binary inputs: three flops, a change is taken once flops 2 and 3 agree
  logic [NUM_BIN-1:0] bin_raw;
  logic [NUM_BIN-1:0] bin_s1;
  logic [NUM_BIN-1:0] bin_s2;
  logic [NUM_BIN-1:0] bin_s3;
  logic [NUM_BIN-1:0] bin_f;
  assign bin_raw = {thermal_reset_in, thermal_block_in, latch_reset_in,
                    inrush_block, breaker_open_status};
  genvar g;
  generate
    for (g = 0; g < NUM_BIN; g++) begin : g_sync
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          bin_s1[g] <= 1'b0;
          bin_s2[g] <= 1'b0;
          bin_s3[g] <= 1'b0;
          bin_f[g]  <= 1'b0;
        end else begin
          bin_s1[g] <= bin_raw[g];
          bin_s2[g] <= bin_s1[g];
          bin_s3[g] <= bin_s2[g];
          if (bin_s2[g] == bin_s3[g]) begin
            bin_f[g] <= bin_s3[g];
          end
        end
      end
    end
  endgenerate

  // settings registers
  logic [15:0] ctrl_reg;
  logic [31:0] uc_reg;
  logic [31:0] ns_reg;
  logic [31:0] bc_reg;
  logic [31:0] limits_reg;
  logic [15:0] full_load_current_setting_reg;
  logic [31:0] decay_reg;
  logic [31:0] ttrip_reg;
  logic [15:0] tratio_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_reg   <= 16'h0000;
      uc_reg     <= 32'h0000_0000;
      ns_reg     <= 32'h0000_0000;
      bc_reg     <= 32'h0000_0000;
      limits_reg <= {16'h0000, BC_BLOCK_RST};
      full_load_current_setting_reg <= 16'(IN_COUNTS);
      decay_reg  <= 32'h0000_0000;
      ttrip_reg  <= ONE_Q16;
      tratio_reg <= 16'h0000;
    end else if (wr) begin
      if (hit(OFS_CTRL))   ctrl_reg   <= wdata[15:0];
      if (hit(OFS_UC))     uc_reg     <= wdata;
      if (hit(OFS_NS))     ns_reg     <= wdata;
      if (hit(OFS_BC))     bc_reg     <= wdata;
      if (hit(OFS_LIMITS)) limits_reg <= wdata;
      if (hit(OFS_FULL_LOAD_CURRENT_SETTING)) full_load_current_setting_reg <= wdata[15:0];
      if (hit(OFS_DECAY))  decay_reg  <= wdata;
      if (hit(OFS_TTRIP))  ttrip_reg  <= wdata;
      if (hit(OFS_TRATIO)) tratio_reg <= wdata[15:0];
    end
  end

  logic cmd_latch_rst;
  logic cmd_theta_rst;
  logic cmd_restore;
  logic latch_clear;
  assign cmd_latch_rst = wr && hit(OFS_CMD) && wdata[CMD_LATCH];
  assign cmd_theta_rst = wr && hit(OFS_CMD) && wdata[CMD_THRST];
  assign cmd_restore   = wr && hit(OFS_CMD) && wdata[CMD_RESTORE];
  assign latch_clear   = cmd_latch_rst || bin_f[BIN_LRST];

  // one tick drives every timer and the replica in TH_RUN; TH_RESTORE cooling steps run once per clock
  logic [31:0] tick_cnt_reg;
  logic        tick_reg;
  logic [31:0] now_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b0;
      now_reg      <= 32'h0000_0000;
    end else begin
      tick_reg <= tick_cnt_reg == 32'(TICK_CYCLES - 1);
      if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
        tick_cnt_reg <= 32'h0000_0000;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      end
      if (tick_reg) now_reg <= now_reg + 32'h0000_0001;
    end
  end

  // largest phase current
  logic [15:0] imax;
  logic        all_above;
  logic [31:0] full_load_current_setting_tenth;
  always_comb begin
    imax = meas.ia;
    if (meas.ib > imax) imax = meas.ib;
    if (meas.ic > imax) imax = meas.ic;
    full_load_current_setting_tenth = 32'(full_load_current_setting_reg) / 32'(COOL_DIV);
    all_above = 32'(meas.ia) > full_load_current_setting_tenth && 32'(meas.ib) > full_load_current_setting_tenth &&
                32'(meas.ic) > full_load_current_setting_tenth;
  end

  // stages: 0 undercurrent, 1 negative sequence, 2 broken conductor
  logic [2:0]  start;
  logic [2:0]  blocked;
  logic [2:0]  op;
  logic [2:0]  latch_reg;
  logic [2:0]  stage_out;
  logic [2:0]  mode [3];
  logic [15:0] delay [3];
  logic [31:0] limit [3];
  logic [31:0] incr [3];
  logic [31:0] timer_reg [3];
  logic        ns_idmt;
  assign ns_idmt = ctrl_reg[CTRL_NS_IDMT];
  assign mode[0] = ctrl_reg[CTRL_UC_LSB +: 3];
  // breaker-gated modes exist for the undercurrent stage only
  assign mode[1] = ctrl_reg[CTRL_NS_LSB +: 3] >= MODE_ALARM_BRK ?
                   MODE_OFF : ctrl_reg[CTRL_NS_LSB +: 3];
  assign mode[2] = ctrl_reg[CTRL_BC_LSB +: 3] >= MODE_ALARM_BRK ?
                   MODE_OFF : ctrl_reg[CTRL_BC_LSB +: 3];
  assign delay[0] = uc_reg[HI_LSB +: 16];
  assign delay[1] = ns_reg[HI_LSB +: 16];
  assign delay[2] = bc_reg[HI_LSB +: 16];

  always_comb begin
    start[0] = imax < uc_reg[15:0];
    start[1] = meas.i2 > ns_reg[15:0];
    start[2] = (32'(meas.i2) << RATIO_Q) > 32'(bc_reg[15:0]) * 32'(meas.i1)
               && imax >= limits_reg[15:0];
    limit[0] = 32'(delay[0]);
    limit[2] = 32'(delay[2]);
    incr[0]  = 32'h0000_0001;
    incr[2]  = 32'h0000_0001;
    // inverse time: integrate the current, so the delay shrinks as it grows
    limit[1] = ns_idmt ? 32'(delay[1]) * 32'(ns_reg[15:0]) : 32'(delay[1]);
    incr[1]  = ns_idmt ? 32'(meas.i2) : 32'h0000_0001;
  end

  generate
    for (g = 0; g < 3; g++) begin : g_stage
      always_comb begin
        blocked[g] = mode[g] == MODE_OFF ||
          (mode[g] == MODE_TRIP_INR && bin_f[BIN_INRUSH]) ||
          ((mode[g] == MODE_ALARM_BRK || mode[g] == MODE_TRIP_BRK) &&
           bin_f[BIN_BRK]);
        op[g] = start[g] && !blocked[g] && timer_reg[g] >= limit[g];
        stage_out[g] = op[g] || latch_reg[g];
      end
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          timer_reg[g] <= 32'h0000_0000;
        end else if (!start[g] || blocked[g]) begin
          timer_reg[g] <= 32'h0000_0000;
        end else if (tick_reg && timer_reg[g] < limit[g]) begin
          timer_reg[g] <= timer_reg[g] + incr[g];
        end
      end
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          latch_reg[g] <= 1'b0;
        end else begin
          // a new trip in the clearing cycle still latches
          latch_reg[g] <= (latch_reg[g] && !latch_clear) ||
                          (op[g] && mode[g] == MODE_TRIP_LTCH);
        end
      end
    end
  endgenerate

  // thermal replica, Q16 fixed point, 1.0 is full thermal state
  th_state_t   th_state_reg;
  logic [31:0] theta_reg;
  logic [31:0] saved_reg;
  logic [31:0] stamp_reg;
  logic [31:0] catchup_reg;
  logic [7:0]  save_cnt_reg;
  logic [15:0] equivalent_current;
  logic [63:0] k_q16;
  logic [63:0] k2;
  logic [31:0] k2_sat;
  logic [15:0] dfac;
  logic [31:0] theta_next;
  logic [31:0] cool_next;
  logic [31:0] reset_thr;
  logic [63:0] denom;

  assign equivalent_current = bin_f[BIN_TBLK] ? 16'h0000 : imax;
  assign dfac = all_above ? decay_reg[HI_LSB +: 16] : decay_reg[15:0];
  assign reset_thr = 32'((64'(ttrip_reg) * 64'(tratio_reg)) >> Q16);
  always_comb begin
    denom = 64'(full_load_current_setting_reg) * 64'(THERM_NUM);
    if (denom == 64'h0000_0000_0000_0000) begin
      k_q16 = 64'h0000_0000_FFFF_FFFF;
    end else begin
      k_q16 = ((64'(equivalent_current) * 64'(THERM_DEN)) << Q16) / denom;
    end
    k2 = (k_q16 * k_q16) >> Q16;
    k2_sat = k2 > 64'h0000_0000_FFFF_FFFF ? 32'hFFFF_FFFF : k2[31:0];
    theta_next = 32'((64'(k2_sat) * (64'(ONE_Q16) - 64'(dfac)) +
                      64'(theta_reg) * 64'(dfac)) >> Q16);
    cool_next = 32'((64'(theta_reg) * 64'(decay_reg[HI_LSB +: 16])) >> Q16);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      th_state_reg <= TH_RUN;
      theta_reg    <= 32'h0000_0000;
      catchup_reg  <= 32'h0000_0000;
    end else if (cmd_theta_rst || bin_f[BIN_TRST]) begin
      th_state_reg <= TH_RUN;
      theta_reg    <= 32'h0000_0000;
      catchup_reg  <= 32'h0000_0000;
    end else if (cmd_restore) begin
      th_state_reg <= TH_RESTORE;
      theta_reg    <= saved_reg;
      catchup_reg  <= now_reg - stamp_reg;
    end else begin
      case (th_state_reg)
        TH_RUN: begin
          if (tick_reg) theta_reg <= theta_next;
        end
        TH_RESTORE: begin
          // one cooling step per clock for each tick that passed unpowered
          if (catchup_reg == 32'h0000_0000) begin
            th_state_reg <= TH_RUN;
          end else begin
            theta_reg   <= cool_next;
            catchup_reg <= catchup_reg - 32'h0000_0001;
          end
        end
        default: th_state_reg <= TH_RUN;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      saved_reg    <= 32'h0000_0000;
      stamp_reg    <= 32'h0000_0000;
      save_cnt_reg <= 8'h00;
    end else if (wr && (hit(OFS_SAVED) || hit(OFS_STAMP))) begin
      if (hit(OFS_SAVED)) saved_reg <= wdata;
      if (hit(OFS_STAMP)) stamp_reg <= wdata;
    end else if (tick_reg) begin
      if (save_cnt_reg == 8'(SAVE_TICKS - 1)) begin
        save_cnt_reg <= 8'h00;
        saved_reg    <= theta_reg;
        stamp_reg    <= now_reg;
      end else begin
        save_cnt_reg <= save_cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      thermal_trip  <= 1'b0;
      thermal_start <= 1'b0;
    end else begin
      thermal_start <= 32'(imax) > limits_reg[HI_LSB +: 16];
      if (theta_reg >= ttrip_reg) begin
        thermal_trip <= 1'b1;
      end else if (theta_reg < reset_thr) begin
        thermal_trip <= 1'b0;
      end
    end
  end

  // outputs
  logic [2:0] trip_sel;
  logic [2:0] alarm_sel;
  logic       trip_next;
  generate
    for (g = 0; g < 3; g++) begin : g_route
      assign trip_sel[g]  = stage_out[g] && is_trip(mode[g]);
      assign alarm_sel[g] = stage_out[g] && is_alarm(mode[g]);
    end
  endgenerate
  assign trip_next = |trip_sel || thermal_trip;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prot_trip       <= 1'b0;
      prot_trip_pulse <= 1'b0;
      alarm           <= 1'b0;
    end else begin
      prot_trip       <= trip_next;
      prot_trip_pulse <= trip_next && !prot_trip;
      alarm           <= |alarm_sel;
    end
  end

  // register reads, data in the following cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        OFS_CTRL:   rdata <= 32'(ctrl_reg);
        OFS_UC:     rdata <= uc_reg;
        OFS_NS:     rdata <= ns_reg;
        OFS_BC:     rdata <= bc_reg;
        OFS_LIMITS: rdata <= limits_reg;
        OFS_FULL_LOAD_CURRENT_SETTING: rdata <= 32'(full_load_current_setting_reg);
        OFS_DECAY:  rdata <= decay_reg;
        OFS_TTRIP:  rdata <= ttrip_reg;
        OFS_TRATIO: rdata <= 32'(tratio_reg);
        OFS_STATUS: rdata <= 32'({bin_f, th_state_reg, thermal_start,
                                  thermal_trip, latch_reg, op, start});
        OFS_THETA:  rdata <= theta_reg;
        OFS_SAVED:  rdata <= saved_reg;
        OFS_STAMP:  rdata <= stamp_reg;
        OFS_NOW:    rdata <= now_reg;
        default:    rdata <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  uc_inrush_blk_a: assert property (
    mode[0] == MODE_TRIP_INR && bin_f[BIN_INRUSH] |-> !op[0])
    else $error("undercurrent operated during inrush");
  uc_brk_blk_a: assert property (
    mode[0] == MODE_TRIP_BRK && bin_f[BIN_BRK] |=> !$past(op[0]))
    else $error("undercurrent operated with breaker open");
  latch_hold_a: assert property (
    latch_reg[0] && !latch_clear |=> latch_reg[0])
    else $error("latched trip dropped without reset");
  bc_low_cur_a: assert property (
    imax < limits_reg[15:0] |-> !start[2])
    else $error("broken conductor started at low current");
  trip_pulse_a: assert property (
    $rose(prot_trip) |-> prot_trip_pulse ##1 !prot_trip_pulse)
    else $error("trip pulse not one cycle at trip rise");
  alarm_route_a: assert property (
    mode[0] == MODE_ALARM && op[0] |=> alarm)
    else $error("alarm mode op did not raise alarm");
  therm_hold_a: assert property (
    thermal_trip && theta_reg >= reset_thr |=> thermal_trip)
    else $error("thermal trip released above reset level");
  therm_clear_a: assert property (
    cmd_theta_rst |=> theta_reg == 32'h0000_0000)
    else $error("thermal state not cleared");
  tick_space_a: assert property (
    tick_reg |=> !tick_reg)
    else $error("tick longer than one cycle");

  uc_trip_c: cover property (op[0] && is_trip(mode[0]) ##1 prot_trip);
  bc_trip_c: cover property (op[2] ##1 prot_trip);
  therm_trip_c: cover property ($rose(thermal_trip));
  latch_c: cover property (latch_reg[1] ##1 latch_clear);
endmodule
`default_nettype wire

// [logic/feeder_prot_pkg.sv]
package feeder_prot_pkg;
  localparam int CUR_W       = 16;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int SYNC_STAGES = 3;
  localparam int NUM_BIN     = 5;
  localparam int CLK_MHZ     = 100;
  localparam int TICK_MS     = 10;
  localparam int SAVE_MS     = 500;
  localparam int TICK_CYCLES_DEF = TICK_MS * CLK_MHZ * 1000;
  localparam int SAVE_TICKS  = SAVE_MS / TICK_MS;

  // currents are in counts; nominal current In is this many counts
  localparam int IN_COUNTS   = 1000;
  localparam logic [15:0] BC_BLOCK_RST = 16'(IN_COUNTS / 10);
  localparam int THERM_NUM   = 105;
  localparam int THERM_DEN   = 100;
  localparam int COOL_DIV    = 10;
  localparam int Q16         = 16;
  localparam int RATIO_Q     = 8;
  localparam logic [31:0] ONE_Q16 = 32'h0001_0000;

  // output modes
  localparam logic [2:0] MODE_OFF       = 3'h0;
  localparam logic [2:0] MODE_ALARM     = 3'h1;
  localparam logic [2:0] MODE_TRIP      = 3'h2;
  localparam logic [2:0] MODE_TRIP_INR  = 3'h3;
  localparam logic [2:0] MODE_TRIP_LTCH = 3'h4;
  localparam logic [2:0] MODE_ALARM_BRK = 3'h5;
  localparam logic [2:0] MODE_TRIP_BRK  = 3'h6;

  // register offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CMD      = 8'h04;
  localparam logic [7:0] OFS_UC       = 8'h08;
  localparam logic [7:0] OFS_NS       = 8'h0C;
  localparam logic [7:0] OFS_BC       = 8'h10;
  localparam logic [7:0] OFS_LIMITS   = 8'h14;
  localparam logic [7:0] OFS_FULL_LOAD_CURRENT_SETTING   = 8'h18;
  localparam logic [7:0] OFS_DECAY    = 8'h1C;
  localparam logic [7:0] OFS_TTRIP    = 8'h20;
  localparam logic [7:0] OFS_TRATIO   = 8'h24;
  localparam logic [7:0] OFS_STATUS   = 8'h28;
  localparam logic [7:0] OFS_THETA    = 8'h2C;
  localparam logic [7:0] OFS_SAVED    = 8'h30;
  localparam logic [7:0] OFS_STAMP    = 8'h34;
  localparam logic [7:0] OFS_NOW      = 8'h38;

  // field positions
  localparam int CTRL_UC_LSB  = 0;
  localparam int CTRL_NS_LSB  = 4;
  localparam int CTRL_BC_LSB  = 8;
  localparam int CTRL_NS_IDMT = 12;
  localparam int CMD_LATCH    = 0;
  localparam int CMD_THRST    = 1;
  localparam int CMD_RESTORE  = 2;
  localparam int HI_LSB       = 16;
  localparam int BIN_BRK      = 0;
  localparam int BIN_INRUSH   = 1;
  localparam int BIN_LRST     = 2;
  localparam int BIN_TBLK     = 3;
  localparam int BIN_TRST     = 4;

  typedef struct packed {
    logic [CUR_W-1:0] ia;
    logic [CUR_W-1:0] ib;
    logic [CUR_W-1:0] ic;
    logic [CUR_W-1:0] i1;
    logic [CUR_W-1:0] i2;
  } meas_t;

  typedef enum logic [1:0] {
    TH_RUN     = 2'b01,
    TH_RESTORE = 2'b10
  } th_state_t;
endpackage

// [sim/meas_source.sv]
`timescale 1ns/1ns
`default_nettype none
module meas_source import feeder_prot_pkg::*; (
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire meas_t              req,
  input  wire logic [NUM_BIN-1:0] bin_req,
  output var  meas_t              meas,
  output var  logic [NUM_BIN-1:0] bin
);
  // the front end answers one sample late, like a real converter pipeline
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meas <= '0;
      bin  <= '0;
    end else begin
      meas <= req;
      bin  <= bin_req;
    end
  end
endmodule
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb import feeder_prot_pkg::*;;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [1:0]  cs;
    logic [3:0]  fl;
  } row_t;
  // fl is {breaker open, inrush, expected trip, expected alarm}
  localparam row_t ROWS [15] = '{
    '{16'h0001, 2'd0, 4'b0001}, '{16'h0002, 2'd0, 4'b0010},
    '{16'h0003, 2'd0, 4'b0100}, '{16'h0003, 2'd0, 4'b0010},
    '{16'h0005, 2'd0, 4'b1000}, '{16'h0005, 2'd0, 4'b0001},
    '{16'h0006, 2'd0, 4'b1000}, '{16'h0006, 2'd0, 4'b0010},
    '{16'h0020, 2'd1, 4'b0010}, '{16'h1010, 2'd1, 4'b0001},
    '{16'h0030, 2'd1, 4'b0100}, '{16'h0200, 2'd2, 4'b0010},
    '{16'h0100, 2'd2, 4'b0001}, '{16'h0300, 2'd2, 4'b0100},
    '{16'h0200, 2'd3, 4'b0000}};
  localparam logic [15:0] CPH [4] = '{16'h0064, 16'h0320, 16'h0190, 16'h0032};
  localparam logic [15:0] CI2 [4] = '{16'h0000, 16'h012C, 16'h012C, 16'h0028};
  localparam logic [31:0] LCTRL [3] = '{32'h0000_0004, 32'h0000_0040,
                                        32'h0000_0400};
  logic               clock;
  logic               rst;
  meas_t              req;
  meas_t              m;
  logic [NUM_BIN-1:0] bin_req;
  logic [NUM_BIN-1:0] bin;
  logic [ADDR_W-1:0]  addr;
  logic [DATA_W-1:0]  wdata;
  logic               wr;
  logic               rd;
  logic [DATA_W-1:0]  rdata;
  logic               prot_trip;
  logic               prot_trip_pulse;
  logic               alarm;
  logic               thermal_trip;
  logic               thermal_start;
  logic [31:0]        v;
  int                 bad_count;
  int                 checks;
  int                 pulses = 0;
  int                 p0;

  meas_source fe (.clock(clock), .rst(rst), .req(req), .bin_req(bin_req),
                  .meas(m), .bin(bin));
  feeder_prot #(.TICK_CYCLES(10)) dut (
    .clock(clock), .rst(rst), .meas(m),
    .breaker_open_status(bin[BIN_BRK]), .inrush_block(bin[BIN_INRUSH]),
    .latch_reset_in(bin[BIN_LRST]), .thermal_block_in(bin[BIN_TBLK]),
    .thermal_reset_in(bin[BIN_TRST]), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .prot_trip(prot_trip),
    .prot_trip_pulse(prot_trip_pulse), .alarm(alarm),
    .thermal_trip(thermal_trip), .thermal_start(thermal_start));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (prot_trip_pulse === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // rdata is taken in the cycle right after the read strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    d = rdata;
  endtask

  task automatic apply(input logic [15:0] ph, input logic [15:0] i2);
    @(posedge clock);
    req <= '{ia: ph, ib: ph, ic: ph, i1: ph, i2: i2};
  endtask

  task automatic therm(input logic [15:0] ib);
    @(posedge clock);
    req <= '{ia: 16'h0064, ib: ib, ic: 16'h0064, i1: ib, i2: 16'h0000};
  endtask

  function automatic logic pick(input int s);
    return s == 0 ? prot_trip : s == 1 ? alarm : thermal_trip;
  endfunction

  // bounded wait; running out of cycles shows up as a mismatch
  task automatic wait_sig(input int s, input logic e);
    for (int n = 0; n < 300 && pick(s) !== e; n++) begin
      @(posedge clock);
    end
    chk({31'h0, pick(s)}, {31'h0, e}, "wait for flag");
    if (pick(s) !== e) begin
      summarize();
    end
  endtask

  initial begin
    rst = 1'b1;
    req = '0;
    bin_req = '0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    bad_count = 0;
    checks = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd_reg(OFS_FULL_LOAD_CURRENT_SETTING, v);
    chk(v, 32'h0000_03E8, "full load reset");
    rd_reg(OFS_TTRIP, v);
    chk(v, 32'h0001_0000, "trip level reset");
    rd_reg(OFS_LIMITS, v);
    chk({16'h0000, v[15:0]}, 32'h0000_0064, "low block reset");
    rd_reg(8'h3C, v);
    chk(v, 32'h0000_0000, "unmapped read");
    wr_reg(OFS_UC, 32'h0002_01F4);
    wr_reg(OFS_NS, 32'h0002_00C8);
    wr_reg(OFS_BC, 32'h0002_0080);
    wr_reg(OFS_LIMITS, 32'hFFFF_0064);
    $display("reset values done");
    for (int r = 0; r < 15; r++) begin
      wr_reg(OFS_CTRL, 32'h0000_0000);
      wr_reg(OFS_CMD, 32'h0000_0001);
      apply(CPH[ROWS[r].cs], CI2[ROWS[r].cs]);
      bin_req <= {3'b000, ROWS[r].fl[2], ROWS[r].fl[3]};
      repeat (20) @(posedge clock);
      p0 = pulses;
      wr_reg(OFS_CTRL, {16'h0000, ROWS[r].ctrl});
      repeat (80) @(posedge clock);
      chk({30'h0, prot_trip, alarm}, {30'h0, ROWS[r].fl[1:0]}, "row out");
      chk(pulses - p0, {31'h0, ROWS[r].fl[1]}, "row pulses");
    end
    $display("mode table done");
    bin_req <= '0;
    for (int k = 0; k < 3; k++) begin
      apply(CPH[k], CI2[k]);
      wr_reg(OFS_CTRL, LCTRL[k]);
      wait_sig(0, 1'b1);
      apply(16'h0320, 16'h0000);
      repeat (60) @(posedge clock);
      chk({31'h0, prot_trip}, 32'h0000_0001, "latch hold");
      if (k == 1) begin
        bin_req[BIN_LRST] <= 1'b1;
        repeat (10) @(posedge clock);
        bin_req[BIN_LRST] <= 1'b0;
      end else begin
        wr_reg(OFS_CMD, 32'h0000_0001);
      end
      wait_sig(0, 1'b0);
    end
    $display("latch done");
    wr_reg(OFS_CTRL, 32'h0000_0000);
    wr_reg(OFS_DECAY, 32'h0000_0000);
    wr_reg(OFS_LIMITS, 32'h07D0_0064);
    wr_reg(OFS_TRATIO, 32'h0000_8000);
    therm(16'h0834);
    wait_sig(2, 1'b1);
    rd_reg(OFS_THETA, v);
    chk(v, 32'h0004_0000, "theta value");
    chk({31'h0, thermal_start}, 32'h0000_0001, "start");
    // at least one periodic save falls inside this wait
    repeat (520) @(posedge clock);
    rd_reg(OFS_SAVED, v);
    chk(v, 32'h0004_0000, "saved theta");
    therm(16'h0348);
    repeat (50) @(posedge clock);
    chk({31'h0, thermal_trip}, 32'h0000_0001, "hysteresis");
    therm(16'h020D);
    wait_sig(2, 1'b0);
    therm(16'h0834);
    wait_sig(2, 1'b1);
    bin_req[BIN_TBLK] <= 1'b1;
    wait_sig(2, 1'b0);
    rd_reg(OFS_THETA, v);
    chk(v, 32'h0000_0000, "blocked theta");
    bin_req[BIN_TBLK] <= 1'b0;
    bin_req[BIN_TRST] <= 1'b1;
    repeat (40) @(posedge clock);
    rd_reg(OFS_THETA, v);
    chk(v, 32'h0000_0000, "reset theta");
    wr_reg(OFS_DECAY, 32'hFFFF_0000);
    apply(16'h0834, 16'h0000);
    bin_req[BIN_TRST] <= 1'b0;
    repeat (30) @(posedge clock);
    rd_reg(OFS_THETA, v);
    chk({31'h0, v < 32'h0000_1000}, 32'h0000_0001, "cooling pick");
    $display("thermal done");
    // theta held at 4.0 so a periodic save cannot change the saved value
    wr_reg(OFS_DECAY, 32'h8000_0000);
    therm(16'h0834);
    repeat (30) @(posedge clock);
    wr_reg(OFS_SAVED, 32'h0004_0000);
    wr_reg(OFS_CMD, 32'h0000_0004);
    rd_reg(OFS_THETA, v);
    chk(v, 32'h0002_0000, "restore cooling step");
    $display("restore done");
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    chk({30'h0, prot_trip, thermal_trip}, 32'h0000_0000, "reset outputs");
    rst <= 1'b0;
    rd_reg(OFS_DECAY, v);
    chk(v, 32'h0000_0000, "decay after reset");
    $display("reset done");
    summarize();
  end
endmodule
`default_nettype wire
